// [verilog/spm_pkg.sv]
// Constants shared by the shared address/data pin multiplexer
package spm_pkg;
  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W = 4;
  localparam int unsigned SYNC_STAGES = 2;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_BUS_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_PB_PEN = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_PB_PUP = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_PB_DIR = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_PB_DAT = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_PF_PEN = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_PF_PUP = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_PF_DIR = 6'h1c;
  localparam logic [ADDR_W-1:0] OFS_PF_DAT = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_PIN_STAT = 6'h24;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned BIT_DRIVE = 0;
  localparam int unsigned BIT_PB0 = 0;
  localparam int unsigned PF_LSB = 9;
  localparam int unsigned PF_W = 7;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic RST_DRIVE = 1'b0;
  localparam logic RST_PB_PEN = 1'b0;
  localparam logic RST_PB_PUP = 1'b0;
  localparam logic RST_PB_DIR = 1'b0;
  localparam logic RST_PB_DAT = 1'b0;
  localparam logic [PF_W-1:0] RST_PF_PEN = 7'h7f;
  localparam logic [PF_W-1:0] RST_PF_PUP = 7'h00;
  localparam logic [PF_W-1:0] RST_PF_DIR = 7'h00;
  localparam logic [PF_W-1:0] RST_PF_DAT = 7'h00;

  // ---------------------------------------------------------------
  // Bus slave states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SPM_BUS_IDLE = 2'b00,
    SPM_BUS_ACK = 2'b01
  } spm_bus_t;
endpackage : spm_pkg

// [verilog/spm_sync.sv]
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module spm_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // No reset: straps must pass through while reset is held
  always_ff @(posedge clk) begin
    meta_q <= d;
    sync_q <= meta_q;
  end

  assign q = sync_q;
endmodule : spm_sync

// [verilog/spm_pin_mux.sv]
// Pin multiplexer for the upper address line and the low data lines
// ---------------------------------------------------------------
// Behaviour
// - Startup address/port choice from straps at reset
// - Peripheral enable write switches address pin use
// - Port B pull-up bit 0 disables pull-up
// - Idle bus: drive bit floats address/control
// - Idle bus: drive bit floats low data
// - Reset: data outputs off, pull-ups on, bus
// - Port F pull-up bits 9..15 disable pull-ups
// - Port pins individually input or output
// ---------------------------------------------------------------
//
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
module spm_pin_mux #(
  parameter int unsigned CTL_W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [spm_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [spm_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [spm_pkg::BE_W-1:0] avs_byteenable,
  output logic [spm_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic external_boot_select,
  input wire logic memory_interface_mode_select,
  input wire logic flash_secure,
  input wire logic mif_bus_active,
  input wire logic mif_addr_out,
  input wire logic [CTL_W-1:0] mif_ctl_out,
  input wire logic [spm_pkg::PF_W-1:0] mif_data_out,
  input wire logic mif_data_oe,
  output logic [spm_pkg::PF_W-1:0] mif_data_in,
  output logic [CTL_W-1:0] mif_ctl_pin_out,
  output logic mif_ctl_pin_oe,
  input wire logic portb_pin_zero_in,
  output logic portb_pin_zero_out,
  output logic portb_pin_zero_oe,
  output logic portb_pin_zero_pullup_en,
  input wire logic [spm_pkg::PF_W-1:0] low_data_lines_in,
  output logic [spm_pkg::PF_W-1:0] low_data_lines_out,
  output logic [spm_pkg::PF_W-1:0] low_data_lines_oe,
  output logic [spm_pkg::PF_W-1:0] low_data_lines_pullup_en
);
  import spm_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Straps pick address use for external boot or unsecured bus mode
  function automatic logic spm_startup_addr(input logic boot, input logic mode,
                                            input logic secure);
    return boot | (mode & ~secure);
  endfunction : spm_startup_addr

  function automatic logic [DATA_W-1:0] spm_pf_word(input logic [PF_W-1:0] v);
    logic [DATA_W-1:0] w;
    w = '0;
    w[PF_LSB +: PF_W] = v;
    return w;
  endfunction : spm_pf_word

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [PF_W+3:0] sync_in, sync_out;
  logic boot_s, mode_s, secure_s, pb_pin_s;
  logic [PF_W-1:0] pf_pin_s;

  assign sync_in = {external_boot_select, memory_interface_mode_select, flash_secure,
                    portb_pin_zero_in, low_data_lines_in};

  spm_sync #(.W(PF_W + 4)) spm_sync_inst (
    .clk(clk),
    .d(sync_in),
    .q(sync_out)
  );

  assign {boot_s, mode_s, secure_s, pb_pin_s, pf_pin_s} = sync_out;

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  spm_bus_t state_q, state_d;
  logic wait_q, wait_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic init_q, init_d, drive_q, drive_d, commit;
  logic pb_pen_q, pb_pen_d, pb_pup_q, pb_pup_d, pb_dir_q, pb_dir_d, pb_dat_q, pb_dat_d;
  logic [PF_W-1:0] pf_pen_q, pf_pen_d, pf_pup_q, pf_pup_d;
  logic [PF_W-1:0] pf_dir_q, pf_dir_d, pf_dat_q, pf_dat_d;

  // Access completes on the edge where waitrequest is seen low
  assign commit = (state_q == SPM_BUS_ACK) && avs_write;

  always_comb begin
    state_d = state_q;
    wait_d = 1'b1;
    rdata_d = rdata_q;
    case (state_q)
      SPM_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          state_d = SPM_BUS_ACK;
          wait_d = 1'b0;
          rdata_d = '0;
          if (avs_read) begin
            case (avs_address)
              OFS_BUS_CTRL: rdata_d[BIT_DRIVE] = drive_q;
              OFS_PB_PEN: rdata_d[BIT_PB0] = pb_pen_q;
              OFS_PB_PUP: rdata_d[BIT_PB0] = pb_pup_q;
              OFS_PB_DIR: rdata_d[BIT_PB0] = pb_dir_q;
              OFS_PB_DAT: rdata_d[BIT_PB0] = pb_dat_q;
              OFS_PF_PEN: rdata_d = spm_pf_word(pf_pen_q);
              OFS_PF_PUP: rdata_d = spm_pf_word(pf_pup_q);
              OFS_PF_DIR: rdata_d = spm_pf_word(pf_dir_q);
              OFS_PF_DAT: rdata_d = spm_pf_word(pf_dat_q);
              OFS_PIN_STAT: rdata_d = spm_pf_word(pf_pin_s) | {{(DATA_W-1){1'b0}}, pb_pin_s};
              default: rdata_d = '0;
            endcase
          end
        end
      end
      SPM_BUS_ACK: begin
        state_d = SPM_BUS_IDLE;
      end
      default: begin
        state_d = SPM_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= SPM_BUS_IDLE;
      wait_q <= 1'b1;
      rdata_q <= '0;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_comb begin
    init_d = 1'b1;
    drive_d = drive_q;
    pb_pen_d = pb_pen_q;
    pb_pup_d = pb_pup_q;
    pb_dir_d = pb_dir_q;
    pb_dat_d = pb_dat_q;
    pf_pen_d = pf_pen_q;
    pf_pup_d = pf_pup_q;
    pf_dir_d = pf_dir_q;
    pf_dat_d = pf_dat_q;
    if (!init_q) begin
      pb_pen_d = spm_startup_addr(boot_s, mode_s, secure_s);
    end
    // Port B bits sit in lane 0; the port F field lies wholly in lane 1
    if (commit) begin
      case (avs_address)
        OFS_BUS_CTRL: if (avs_byteenable[0]) drive_d = avs_writedata[BIT_DRIVE];
        OFS_PB_PEN: if (avs_byteenable[0]) pb_pen_d = avs_writedata[BIT_PB0];
        OFS_PB_PUP: if (avs_byteenable[0]) pb_pup_d = avs_writedata[BIT_PB0];
        OFS_PB_DIR: if (avs_byteenable[0]) pb_dir_d = avs_writedata[BIT_PB0];
        OFS_PB_DAT: if (avs_byteenable[0]) pb_dat_d = avs_writedata[BIT_PB0];
        OFS_PF_PEN: if (avs_byteenable[1]) pf_pen_d = avs_writedata[PF_LSB +: PF_W];
        OFS_PF_PUP: if (avs_byteenable[1]) pf_pup_d = avs_writedata[PF_LSB +: PF_W];
        OFS_PF_DIR: if (avs_byteenable[1]) pf_dir_d = avs_writedata[PF_LSB +: PF_W];
        OFS_PF_DAT: if (avs_byteenable[1]) pf_dat_d = avs_writedata[PF_LSB +: PF_W];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      init_q <= 1'b0;
      drive_q <= RST_DRIVE;
      pb_pen_q <= RST_PB_PEN;
      pb_pup_q <= RST_PB_PUP;
      pb_dir_q <= RST_PB_DIR;
      pb_dat_q <= RST_PB_DAT;
      pf_pen_q <= RST_PF_PEN;
      pf_pup_q <= RST_PF_PUP;
      pf_dir_q <= RST_PF_DIR;
      pf_dat_q <= RST_PF_DAT;
    end else begin
      init_q <= init_d;
      drive_q <= drive_d;
      pb_pen_q <= pb_pen_d;
      pb_pup_q <= pb_pup_d;
      pb_dir_q <= pb_dir_d;
      pb_dat_q <= pb_dat_d;
      pf_pen_q <= pf_pen_d;
      pf_pup_q <= pf_pup_d;
      pf_dir_q <= pf_dir_d;
      pf_dat_q <= pf_dat_d;
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  logic pb_out_d, pb_oe_d, pb_pu_d, ctl_oe_d, dbus_oe;
  logic [CTL_W-1:0] ctl_out_d;
  logic [PF_W-1:0] pf_out_d, pf_oe_d, pf_pu_d;

  always_comb begin
    // Address and controls float only if idle without drive
    ctl_oe_d = mif_bus_active | drive_q;
    ctl_out_d = mif_ctl_out;
    // Port mode takes port registers, bus ignored
    pb_out_d = pb_pen_q ? mif_addr_out : pb_dat_q;
    pb_oe_d = pb_pen_q ? ctl_oe_d : pb_dir_q;
    // Idle data lines follow the drive bit
    dbus_oe = mif_bus_active ? mif_data_oe : drive_q;
    pf_out_d = (pf_pen_q & mif_data_out) | (~pf_pen_q & pf_dat_q);
    pf_oe_d = (pf_pen_q & {PF_W{dbus_oe}}) | (~pf_pen_q & pf_dir_q);
    pb_pu_d = ~pb_pup_q;
    pf_pu_d = ~pf_pup_q;
  end

  // Reset leaves outputs off and pull-ups on
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      portb_pin_zero_out <= 1'b0;
      portb_pin_zero_oe <= 1'b0;
      portb_pin_zero_pullup_en <= 1'b1;
      mif_ctl_pin_out <= '0;
      mif_ctl_pin_oe <= 1'b0;
      low_data_lines_out <= '0;
      low_data_lines_oe <= '0;
      low_data_lines_pullup_en <= '1;
      mif_data_in <= '0;
    end else begin
      portb_pin_zero_out <= pb_out_d;
      portb_pin_zero_oe <= pb_oe_d;
      portb_pin_zero_pullup_en <= pb_pu_d;
      mif_ctl_pin_out <= ctl_out_d;
      mif_ctl_pin_oe <= ctl_oe_d;
      low_data_lines_out <= pf_out_d;
      low_data_lines_oe <= pf_oe_d;
      low_data_lines_pullup_en <= pf_pu_d;
      mif_data_in <= pf_pin_s;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_write(logic [ADDR_W-1:0] a, int lane);
    state_q == SPM_BUS_ACK && avs_write && avs_address == a && avs_byteenable[lane];
  endsequence

  a_startup_strap: assert property (!init_q |=>
    pb_pen_q == spm_startup_addr($past(boot_s), $past(mode_s), $past(secure_s)))
    else $error("startup pin function wrong");
  a_pen_write: assert property (s_write(OFS_PB_PEN, 0) |=>
    pb_pen_q == $past(avs_writedata[BIT_PB0]))
    else $error("port B enable write lost");
  a_pb_pullup: assert property (s_write(OFS_PB_PUP, 0) ##0 avs_writedata[BIT_PB0]
    ##1 !commit |=> !portb_pin_zero_pullup_en)
    else $error("port B pull-up not disabled");
  a_addr_float: assert property (pb_pen_q && !mif_bus_active && !drive_q |=>
    !portb_pin_zero_oe && !mif_ctl_pin_oe)
    else $error("address pin not floated");
  a_data_float: assert property (!mif_bus_active && !drive_q |=>
    (low_data_lines_oe & $past(pf_pen_q)) == '0)
    else $error("data lines not floated");
  a_reset_data: assert property (disable iff (1'b0) !rst_n |=>
    low_data_lines_oe == '0 && &low_data_lines_pullup_en && &pf_pen_q)
    else $error("data lines wrong in reset");
  a_pf_pullup: assert property (s_write(OFS_PF_PUP, 1) |->
    ##2 low_data_lines_pullup_en == ~$past(avs_writedata[PF_LSB +: PF_W], 2))
    else $error("port F pull-up mismatch");
  a_port_dir: assert property (1'b1 |=>
    ((low_data_lines_oe ^ $past(pf_dir_q)) & ~$past(pf_pen_q)) == '0)
    else $error("port F direction not followed");
  a_port_route: assert property (!pb_pen_q |=>
    portb_pin_zero_oe == $past(pb_dir_q) && portb_pin_zero_out == $past(pb_dat_q))
    else $error("port B not routed from port logic");
endmodule : spm_pin_mux

// [bench/spm_mem_model.sv]
// Memory-side model of the seven shared low data pins
`timescale 1ns/10ps
module spm_mem_model (
  input wire logic clk,
  input wire logic mem_drive,
  input wire logic [spm_pkg::PF_W-1:0] mem_val,
  input wire logic [spm_pkg::PF_W-1:0] dev_out,
  input wire logic [spm_pkg::PF_W-1:0] dev_oe,
  input wire logic [spm_pkg::PF_W-1:0] dev_pu,
  output logic [spm_pkg::PF_W-1:0] pin
);
  import spm_pkg::*;
  logic [PF_W-1:0] last_q;
  // ---------------------------------------------------------------
  // Pin resolution
  // ---------------------------------------------------------------
  // Floating pin without pull-up flips, so no stale level passes
  always_comb begin
    for (int i = 0; i < PF_W; i++) begin
      if (dev_oe[i]) pin[i] = dev_out[i];
      else if (mem_drive) pin[i] = mem_val[i];
      else if (dev_pu[i]) pin[i] = 1'b1;
      else pin[i] = ~last_q[i];
    end
  end
  always_ff @(posedge clk) last_q <= pin;
endmodule : spm_mem_model

// [bench/tb_spm_pin_mux.sv]
// Self-checking bench for the shared address/data pin multiplexer
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_spm_pin_mux;
  import spm_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [DATA_W-1:0] wdat = '0;
  logic [DATA_W-1:0] rdat;
  logic [DATA_W-1:0] rv;
  logic [BE_W-1:0] be = 4'hf;
  logic wreq;
  logic boot = 1'b0, mode = 1'b0, sec = 1'b0;
  logic bact = 1'b0, aout = 1'b0, doe = 1'b0, mdrv = 1'b0;
  logic [3:0] ctl = 4'h0;
  logic [3:0] cpo;
  logic [PF_W-1:0] dout = '0, mval = '0;
  logic [PF_W-1:0] din, dpin, dlo, dloe, dpu;
  logic cpoe, bo, boe, bpu, bpin;
  int err_total = 0;
  int n_compared = 0;

  initial forever #25 clk = ~clk;
  // Port B pin: pulled up, else flips when floating
  assign bpin = boe ? bo : (bpu ? 1'b1 : ~bo);

  spm_pin_mux spm_pin_mux_inst (
    .clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .external_boot_select(boot),
    .memory_interface_mode_select(mode), .flash_secure(sec),
    .mif_bus_active(bact), .mif_addr_out(aout), .mif_ctl_out(ctl),
    .mif_data_out(dout), .mif_data_oe(doe), .mif_data_in(din),
    .mif_ctl_pin_out(cpo), .mif_ctl_pin_oe(cpoe), .portb_pin_zero_in(bpin),
    .portb_pin_zero_out(bo), .portb_pin_zero_oe(boe), .portb_pin_zero_pullup_en(bpu),
    .low_data_lines_in(dpin), .low_data_lines_out(dlo), .low_data_lines_oe(dloe),
    .low_data_lines_pullup_en(dpu)
  );

  spm_mem_model spm_mem_model_inst (
    .clk(clk), .mem_drive(mdrv), .mem_val(mval), .dev_out(dlo), .dev_oe(dloe),
    .dev_pu(dpu), .pin(dpin)
  );

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int k;
    k = 0;
    @(posedge clk);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 20);
    rv = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    if (k >= 20) begin
      err_total++;
      end_sim();
    end
  endtask : bus

  task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus(1'b1, a, d);
  endtask : wreg

  task automatic chkreg(input string nm, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] e);
    bus(1'b0, a, '0);
    `CHK(nm, e, rv)
  endtask : chkreg

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask : settle

  task automatic do_reset(input logic [2:0] st);
    @(posedge clk);
    rst_n <= 1'b0;
    {boot, mode, sec} <= st;
    settle(16);
    `CHK("rst_dloe", 7'h00, dloe)
    `CHK("rst_dpu", 7'h7f, dpu)
    `CHK("rst_boe", 1'b0, boe)
    `CHK("rst_bpu", 1'b1, bpu)
    rst_n <= 1'b1;
  endtask : do_reset

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    for (int s = 0; s < 8; s++) begin
      do_reset(s[2:0]);
      chkreg("pb_pen", OFS_PB_PEN, {31'h0, s[2] | (s[1] & ~s[0])});
    end
    chkreg("bus_ctrl", OFS_BUS_CTRL, 32'h0);
    chkreg("pf_pen", OFS_PF_PEN, 32'h0000fe00);
    chkreg("unmapped", 6'h3c, 32'h0);
    $display("test straps done");
    @(posedge clk);
    aout <= 1'b1;
    ctl <= 4'ha;
    dout <= 7'h5a;
    doe <= 1'b1;
    mdrv <= 1'b1;
    mval <= 7'h2a;
    settle(5);
    `CHK("idle_boe", 1'b0, boe)
    `CHK("idle_cpoe", 1'b0, cpoe)
    `CHK("idle_dloe", 7'h00, dloe)
    `CHK("mif_in", 7'h2a, din)
    chkreg("pin_stat", OFS_PIN_STAT, 32'h00005401);
    mdrv <= 1'b0;
    wreg(OFS_BUS_CTRL, 32'h1);
    settle(2);
    `CHK("drive_boe", 1'b1, boe)
    `CHK("drive_bo", 1'b1, bo)
    `CHK("drive_cpo", 4'ha, cpo)
    `CHK("drive_cpoe", 1'b1, cpoe)
    `CHK("drive_dloe", 7'h7f, dloe)
    `CHK("drive_dlo", 7'h5a, dlo)
    bact <= 1'b1;
    doe <= 1'b0;
    wreg(OFS_BUS_CTRL, 32'h0);
    settle(2);
    `CHK("act_dloe", 7'h00, dloe)
    `CHK("act_boe", 1'b1, boe)
    `CHK("act_cpoe", 1'b1, cpoe)
    $display("test bus drive done");
    wreg(OFS_PB_DIR, 32'h1);
    wreg(OFS_PB_DAT, 32'h0);
    wreg(OFS_PB_PEN, 32'h0);
    settle(2);
    `CHK("pb_port_oe", 1'b1, boe)
    `CHK("pb_port_out", 1'b0, bo)
    wreg(OFS_PB_DIR, 32'h0);
    wreg(OFS_PB_PUP, 32'h1);
    settle(2);
    `CHK("pb_in_oe", 1'b0, boe)
    `CHK("pb_pu_off", 1'b0, bpu)
    wreg(OFS_PB_PEN, 32'h1);
    settle(2);
    `CHK("pb_addr", 1'b1, bo & boe)
    $display("test port b done");
    wreg(OFS_PF_PUP, 32'h00000200);
    settle(2);
    `CHK("pf_pu9", 7'h7e, dpu)
    wreg(OFS_PF_PUP, 32'h0000fe00);
    wreg(OFS_PF_DIR, 32'h0000aa00);
    wreg(OFS_PF_DAT, 32'h00006600);
    doe <= 1'b1;
    mdrv <= 1'b1;
    wreg(OFS_PF_PEN, 32'h0);
    settle(5);
    `CHK("pf_pu_all", 7'h00, dpu)
    `CHK("pf_oe", 7'h55, dloe)
    `CHK("pf_out", 7'h33, dlo)
    bus(1'b0, OFS_PIN_STAT, '0);
    `CHK("pf_pins", (7'h33 & 7'h55) | (7'h2a & ~7'h55), rv[15:9])
    // Lane 1 off: the port F pull-up field must keep its value
    be <= 4'h1;
    wreg(OFS_PF_PUP, 32'h0);
    be <= 4'hf;
    chkreg("pf_pup_lane", OFS_PF_PUP, 32'h0000fe00);
    $display("test port f done");
    end_sim();
  end
endmodule : tb_spm_pin_mux
